// ---- rtl/nand_host_map.vh ----
`ifndef NAND_HOST_MAP_VH
`define NAND_HOST_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL          5'h00
`define REG_ADDR          5'h04
`define REG_DATA          5'h08
`define REG_STAT          5'h0C
`define REG_CFG           5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_OP_MSB       2
`define CTRL_CLR_ERR_BIT  8
`define CFG_WP_REL_BIT    0
`define STAT_BUSY_BIT     8
`define STAT_RB_BIT       9
`define STAT_ERR_BIT      10
`define STAT_CACHE_BIT    11
`define STAT_PAGES_LSB    12
`define SR_WRITE_UNPROT   7
`define SR_CACHE_OR_ENG   6
`define SR_ENGINE_READY   5
`define SR_PREV_FAIL      1
`define SR_OP_FAIL        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ADDR          32'h0000_0000
`define RST_STATUS        8'h00
`define RST_WP_REL        1'b0

// ----------------------------------------------------------------
// Operations written to the control register
// ----------------------------------------------------------------
`define OP_POLL           3'h0
`define OP_PROG_SETUP     3'h1
`define OP_PROG_CACHE     3'h2
`define OP_PROG_FINAL     3'h3
`define OP_PROG_FIN_CACHE 3'h4
`define OP_ERASE          3'h5
`define OP_RESET          3'h6
`define OP_STATUS         3'h7

// ----------------------------------------------------------------
// Command codes and bus cycle kinds
// ----------------------------------------------------------------
`define CMD_PROG_SETUP    8'h80
`define CMD_PROG_CONFIRM  8'h10
`define CMD_CACHE_CONFIRM 8'h15
`define CMD_ERASE_SETUP   8'h60
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_RESET         8'hFF
`define CMD_STATUS        8'h70
`define KIND_CMD          2'h0
`define KIND_ADDR         2'h1
`define KIND_DIN          2'h2
`define KIND_DOUT         2'h3

// ----------------------------------------------------------------
// Timing and limits
// ----------------------------------------------------------------
`define SYS_CLK_MHZ       40
`define T_SETUP_NS        25
`define T_PULSE_NS        50
`define T_HOLD_NS         25
`define T_WB_NS           100
`define SYNC_LAT          2
`define PAGE_BYTES        2112
`define MAX_CACHE_PAGES   64
`define ERASE_ADDR_CYC    3

`endif

// ---- rtl/nand_bus_cycle.v ----
`timescale 1ns/100ps
`include "nand_host_map.vh"

module nand_bus_cycle #(
    parameter SETUP_CYC = 1,
    parameter PULSE_CYC = 2,
    parameter HOLD_CYC  = 1,
    parameter SYNC_LAT  = 2
) (
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       clk_en,
    input  wire       start,
    input  wire [1:0] kind,
    input  wire [7:0] wdata,
    input  wire [7:0] io_in_sync,
    output reg        done,
    output reg  [7:0] rdata,
    output reg        cle,
    output reg        ale,
    output reg        we_n,
    output reg        re_n,
    output reg  [7:0] io_out,
    output reg        io_oe
);
    // ----------------------------------------------------------------
    // Phase timing
    // ----------------------------------------------------------------
    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_SETUP = 2'h1;
    localparam [1:0] S_PULSE = 2'h2;
    localparam [1:0] S_HOLD  = 2'h3;
    localparam integer N_SETUP = SETUP_CYC - 1;
    localparam integer N_WR    = PULSE_CYC - 1;
    // Read strobe stretched so the synchronised bus has settled
    localparam integer N_RD    = PULSE_CYC + SYNC_LAT - 1;
    localparam integer N_HOLD  = HOLD_CYC - 1;

    reg [1:0] state;
    reg [7:0] cnt;
    reg       is_read;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= S_IDLE;
            cnt     <= 8'h00;
            is_read <= 1'b0;
            done    <= 1'b0;
            rdata   <= 8'h00;
            cle     <= 1'b0;
            ale     <= 1'b0;
            we_n    <= 1'b1;
            re_n    <= 1'b1;
            io_out  <= 8'h00;
            io_oe   <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        is_read <= (kind == `KIND_DOUT);
                        cle     <= (kind == `KIND_CMD);
                        ale     <= (kind == `KIND_ADDR);
                        io_out  <= wdata;
                        io_oe   <= (kind != `KIND_DOUT);
                        cnt     <= N_SETUP[7:0];
                        state   <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        we_n  <= is_read;
                        re_n  <= ~is_read;
                        cnt   <= is_read ? N_RD[7:0] : N_WR[7:0];
                        state <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        if (is_read) begin
                            rdata <= io_in_sync;
                        end
                        we_n  <= 1'b1;
                        re_n  <= 1'b1;
                        cnt   <= N_HOLD[7:0];
                        state <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        cle   <= 1'b0;
                        ale   <= 1'b0;
                        io_oe <= 1'b0;
                        done  <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // nand_bus_cycle

// ---- rtl/nand_host_ctrl.v ----
// Contract
// (RQ1) Host keeps cache pages in one block
// (RQ2) Setup, four addresses, up to 2112 bytes
// (RQ3) Confirm moves cache to buffer, busy
// (RQ4) New cache command once cache empties
// (RQ5) Transfer waits for pending array program
// (RQ6) Engine ready bit tracks internal programming
// (RQ7) Previous and current page fail flags
// (RQ8) Ready/busy-only host ends with 10h
// (RQ9) Final 15h needs engine ready polling
// (RQ10) At most 64 pages per cache sequence
// (RQ11) Erase sets whole block to one
// (RQ12) Erase: setup, block addresses, confirm
// (RQ13) Erase starts at confirm write strobe
// (RQ14) Erase busy accepts only status, reset
// (RQ15) Erase end: ready, fail flag valid
// (RQ16) Reset aborts operation, clears status
// (RQ17) Reset during reset state is ignored
// (RQ18) Reset holds busy for reset time
// (RQ19) Status driven continuously after command
// (RQ20) Status mode persists until next command
// (RQ21) Top bit unprotected, bits 4-2 reserved
// (RQ22) Bit 6 cache ready or engine idle
// (RQ23) Program busy accepts only status, reset
// (RQ24) Busy low through erase until flag
`timescale 1ns/100ps
`include "nand_host_map.vh"

module nand_host_ctrl #(
    parameter PAGE_BYTES      = `PAGE_BYTES,
    parameter MAX_CACHE_PAGES = `MAX_CACHE_PAGES,
    parameter ERASE_ADDR_CYC  = `ERASE_ADDR_CYC,
    parameter BLOCK_SHIFT     = 6
) (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output wire        ce_n,
    output wire        cle,
    output wire        ale,
    output wire        we_n,
    output wire        re_n,
    output reg         wp_n,
    input  wire        ready_busy_output,
    input  wire [7:0]  io_in,
    output wire [7:0]  io_out,
    output wire        io_oe
);
    // ----------------------------------------------------------------
    // Timing in cycles
    // ----------------------------------------------------------------
    localparam integer RAW_SU = (`T_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000;
    localparam integer RAW_PW = (`T_PULSE_NS * `SYS_CLK_MHZ + 999) / 1000;
    localparam integer RAW_HD = (`T_HOLD_NS * `SYS_CLK_MHZ + 999) / 1000;
    localparam integer RAW_WB = (`T_WB_NS * `SYS_CLK_MHZ + 999) / 1000;
    localparam integer SU_CYC = (RAW_SU < 1) ? 1 : RAW_SU;
    localparam integer PW_CYC = (RAW_PW < 1) ? 1 : RAW_PW;
    localparam integer HD_CYC = (RAW_HD < 1) ? 1 : RAW_HD;
    // Busy may rise late; ignore the pin until it surely has
    localparam integer WB_CYC = RAW_WB + `SYNC_LAT;
    localparam integer PAGE_MAX  = PAGE_BYTES;
    localparam integer PAGES_MAX = MAX_CACHE_PAGES;
    localparam integer ER_CYC    = ERASE_ADDR_CYC;

    localparam [2:0] M_IDLE = 3'h0;
    localparam [2:0] M_CYC  = 3'h1;
    localparam [2:0] M_WAIT = 3'h2;
    localparam [2:0] M_TWB  = 3'h3;
    localparam [2:0] M_RB   = 3'h4;
    localparam [2:0] M_DATA = 3'h5;

    reg  [2:0]  state;
    reg  [2:0]  op_r;
    reg  [2:0]  step;
    reg  [7:0]  wb_cnt;
    reg  [31:0] addr;
    reg  [7:0]  status_byte;
    reg         seq_err;
    reg         in_cache;
    reg         prog_open;
    reg  [6:0]  pages;
    reg  [11:0] data_cnt;
    reg  [15:0] first_block_row;
    reg  [7:0]  din_byte;
    reg         rd_ack;
    reg  [1:0]  rb_meta;
    reg  [7:0]  io_s1;
    reg  [7:0]  io_s2;
    reg         cyc_start;
    reg  [1:0]  st_kind;
    reg  [7:0]  st_byte;
    reg         st_last;
    wire        cyc_done;
    wire [7:0]  cyc_rdata;
    wire        rb_sync;
    wire        idle;
    wire        wr_ctrl;
    wire        wr_data;
    wire        wr_take;
    wire [2:0]  new_op;
    wire        block_differs;
    wire        refuse_op;
    wire        refuse_data;
    wire        clr_err;
    wire        set_err;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rb_meta  <= 2'h0;
            io_s1    <= 8'h00;
            io_s2    <= 8'h00;
        end else if (clk_en) begin
            rb_meta <= {rb_meta[0], ready_busy_output};
            io_s1   <= io_in;
            io_s2   <= io_s1;
        end
    end
    assign rb_sync = rb_meta[1];

    // ----------------------------------------------------------------
    // Avalon slave
    // ----------------------------------------------------------------
    assign idle    = (state == M_IDLE);
    assign wr_ctrl = avs_write && (avs_address == `REG_CTRL);
    assign wr_data = avs_write && (avs_address == `REG_DATA);
    // Ops and data stall the master until the engine is free
    assign wr_take = clk_en && avs_write && (idle || !(wr_ctrl || wr_data));
    assign avs_waitrequest = (avs_read && !rd_ack) ||
                             (avs_write && !wr_take);
    assign new_op  = avs_writedata[`CTRL_OP_MSB:0];
    assign clr_err = wr_take && wr_ctrl &&
                     avs_writedata[`CTRL_CLR_ERR_BIT];

    assign block_differs = (addr[31:16+BLOCK_SHIFT] !=
                            first_block_row[15:BLOCK_SHIFT]);
    assign refuse_op =
        ((new_op == `OP_PROG_SETUP) && in_cache &&
         (block_differs ||                                  // RQ1
          pages >= PAGES_MAX)) ||                           // RQ10
        ((new_op == `OP_PROG_CACHE || new_op == `OP_PROG_FINAL ||
          new_op == `OP_PROG_FIN_CACHE) && !prog_open);
    assign refuse_data = !prog_open || (data_cnt >= PAGE_MAX); // RQ2
    assign set_err = wr_take && ((wr_ctrl && new_op != `OP_POLL &&
                     refuse_op) || (wr_data && refuse_data));

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ack       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            addr         <= `RST_ADDR;
            wp_n         <= `RST_WP_REL;
            seq_err      <= 1'b0;
        end else if (clk_en) begin
            rd_ack <= avs_read && !rd_ack;
            if (avs_read && !rd_ack) begin
                case (avs_address)
                    `REG_ADDR: avs_readdata <= addr;
                    `REG_STAT: avs_readdata <= {13'h0000, pages, in_cache,
                                   seq_err, rb_sync, !idle, status_byte};
                    `REG_CFG:  avs_readdata <= {31'h0000_0000, wp_n};
                    default:   avs_readdata <= 32'h0000_0000;
                endcase
            end
            if (wr_take && avs_address == `REG_ADDR) begin
                addr <= avs_writedata;
            end
            if (wr_take && avs_address == `REG_CFG) begin
                wp_n <= avs_writedata[`CFG_WP_REL_BIT];
            end
            // Hardware set beats software clear
            if (set_err) begin
                seq_err <= 1'b1;
            end else if (clr_err) begin
                seq_err <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Step table
    // ----------------------------------------------------------------
    always @* begin
        st_kind = `KIND_CMD;
        st_byte = 8'h00;
        st_last = 1'b0;
        case (op_r)
            `OP_PROG_SETUP: begin
                st_kind = (step == 3'h0) ? `KIND_CMD : `KIND_ADDR;
                st_last = (step == 3'h4);                      // RQ2
                case (step)
                    3'h0:    st_byte = `CMD_PROG_SETUP;
                    3'h1:    st_byte = addr[7:0];
                    3'h2:    st_byte = addr[15:8];
                    3'h3:    st_byte = addr[23:16];
                    default: st_byte = addr[31:24];
                endcase
            end
            `OP_PROG_CACHE, `OP_PROG_FIN_CACHE: begin
                st_byte = `CMD_CACHE_CONFIRM;                  // RQ9
                st_last = 1'b1;
            end
            `OP_PROG_FINAL: begin
                st_byte = `CMD_PROG_CONFIRM;                   // RQ8
                st_last = 1'b1;
            end
            `OP_ERASE: begin
                st_kind = (step == 3'h0 || step > ER_CYC) ?
                          `KIND_CMD : `KIND_ADDR;
                st_last = (step > ER_CYC);                     // RQ12
                if (step == 3'h0) begin
                    st_byte = `CMD_ERASE_SETUP;
                end else if (step > ER_CYC) begin
                    st_byte = `CMD_ERASE_CONFIRM;              // RQ13
                end else if (step == 3'h1) begin
                    st_byte = addr[23:16];
                end else if (step == 3'h2) begin
                    st_byte = addr[31:24];
                end else begin
                    st_byte = 8'h00;
                end
            end
            `OP_RESET: begin
                st_byte = `CMD_RESET;                          // RQ16
                st_last = 1'b1;
            end
            default: begin
                // Status and poll: command then one read
                st_kind = (step == 3'h0) ? `KIND_CMD : `KIND_DOUT;
                st_byte = `CMD_STATUS;                         // RQ19
                st_last = (step != 3'h0);
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Operation sequencer
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state           <= M_IDLE;
            op_r            <= `OP_STATUS;
            step            <= 3'h0;
            wb_cnt          <= 8'h00;
            status_byte     <= `RST_STATUS;
            in_cache        <= 1'b0;
            prog_open       <= 1'b0;
            pages           <= 7'h00;
            data_cnt        <= 12'h000;
            first_block_row <= 16'h0000;
            din_byte        <= 8'h00;
            cyc_start       <= 1'b0;
        end else if (clk_en) begin
            cyc_start <= 1'b0;
            case (state)
                M_IDLE: begin
                    if (wr_take && wr_ctrl && new_op != `OP_POLL &&
                        !refuse_op) begin
                        op_r  <= new_op;
                        step  <= 3'h0;
                        state <= M_CYC;
                        if (new_op == `OP_PROG_SETUP) begin
                            prog_open <= 1'b1;
                            data_cnt  <= 12'h000;
                            if (!in_cache) begin
                                first_block_row <= addr[31:16];
                            end
                        end
                    end else if (wr_take && wr_data && !refuse_data) begin
                        din_byte  <= avs_writedata[7:0];
                        data_cnt  <= data_cnt + 12'h001;
                        cyc_start <= 1'b1;
                        state     <= M_DATA;
                    end
                end
                M_DATA: begin
                    if (cyc_done) begin
                        state <= M_IDLE;
                    end
                end
                M_CYC: begin
                    cyc_start <= 1'b1;
                    state     <= M_WAIT;
                end
                M_WAIT: begin
                    if (cyc_done && !st_last) begin
                        step  <= step + 3'h1;
                        state <= M_CYC;
                    end else if (cyc_done) begin
                        if (st_kind == `KIND_DOUT) begin
                            status_byte <= cyc_rdata;          // RQ7
                        end
                        wb_cnt <= WB_CYC[7:0];
                        case (op_r)
                            `OP_PROG_SETUP: state <= M_IDLE;
                            `OP_STATUS:     state <= M_IDLE;
                            `OP_PROG_FIN_CACHE: begin
                                op_r      <= `OP_POLL;
                                step      <= 3'h0;
                                prog_open <= 1'b0;
                                in_cache  <= 1'b0;
                                pages     <= 7'h00;
                                state     <= M_CYC;
                            end
                            `OP_POLL: begin
                                // Stay in status mode, re-read only
                                if (!cyc_rdata[`SR_ENGINE_READY]) begin
                                    step  <= 3'h1;             // RQ20
                                    state <= M_CYC;            // RQ9
                                end else begin
                                    state <= M_IDLE;           // RQ6
                                end
                            end
                            default: begin
                                prog_open <= 1'b0;
                                if (op_r == `OP_PROG_CACHE) begin
                                    in_cache <= 1'b1;
                                    pages    <= pages + 7'h01;
                                end else begin
                                    in_cache <= 1'b0;
                                    pages    <= 7'h00;
                                end
                                state <= M_TWB;
                            end
                        endcase
                    end
                end
                M_TWB: begin
                    if (wb_cnt != 8'h00) begin
                        wb_cnt <= wb_cnt - 8'h01;
                    end else begin
                        state <= M_RB;
                    end
                end
                M_RB: begin
                    // No command while busy; ready means cache emptied
                    if (rb_sync) begin                         // RQ23
                        if (op_r == `OP_PROG_FINAL ||
                            op_r == `OP_ERASE) begin           // RQ14
                            op_r  <= `OP_STATUS;               // RQ15
                            step  <= 3'h0;
                            state <= M_CYC;
                        end else begin
                            state <= M_IDLE;                   // RQ4
                        end
                    end
                end
                default: state <= M_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin cycle engine
    // ----------------------------------------------------------------
    assign ce_n = idle;

    nand_bus_cycle #(
        .SETUP_CYC (SU_CYC),
        .PULSE_CYC (PW_CYC),
        .HOLD_CYC  (HD_CYC),
        .SYNC_LAT  (`SYNC_LAT)
    ) u_cycle (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .start      (cyc_start),
        .kind       ((state == M_DATA) ? `KIND_DIN : st_kind),
        .wdata      ((state == M_DATA) ? din_byte : st_byte),
        .io_in_sync (io_s2),
        .done       (cyc_done),
        .rdata      (cyc_rdata),
        .cle        (cle),
        .ale        (ale),
        .we_n       (we_n),
        .re_n       (re_n),
        .io_out     (io_out),
        .io_oe      (io_oe)
    );
endmodule // nand_host_ctrl

// ---- tb/nand_host_ctrl_checker.sv ----
`timescale 1ns/100ps
module nand_host_ctrl_checker(
    input wire       sys_clk, rst_b, avs_read, avs_waitrequest,
    input wire       ce_n, cle, ale, we_n, re_n, io_oe,
    input wire [7:0] io_out
);
    // ---
    // Pin protocol
    // ---
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence wr_pulse; !we_n ##1 we_n; endsequence
    sequence rd_pulse; !re_n [*3] ##1 re_n; endsequence
    lat_excl_a: assert property (!(cle && ale)) else $error("cle ale");
    sel_lat_a: assert property ((cle || ale) |-> !ce_n) else $error("ce");
    wr_drive_a: assert property (!we_n |-> io_oe) else $error("oe");
    rd_float_a: assert property (!re_n |-> !io_oe) else $error("oe");
    wr_len_a: assert property ($fell(we_n) |=> wr_pulse) else $error("we");
    rd_len_a: assert property ($fell(re_n) |=> rd_pulse) else $error("re");
    wr_hold_a: assert property (!we_n ##1 !we_n |-> $stable(io_out))
        else $error("io");
    bus_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest
        ##1 !avs_waitrequest) else $error("wait");
endmodule // nand_host_ctrl_checker

// ---- tb/nand_flash_model.sv ----
`timescale 1ns/100ps
module nand_flash_model(
    input  wire       ce_n, cle, we_n, re_n, wp_n, fail_in,
    input  wire [7:0] io_out,
    output wire       rb,
    output wire [7:0] io_in
);
    // ---
    // Device state
    // ---
    reg        busy = 1'b0;
    reg        pf = 1'b0;
    reg        cur = 1'b0;
    reg        rs = 1'b1;
    wire [7:0] sr = {wp_n, !busy, !busy, 3'h0, pf, cur};
    assign rb = !busy;
    // Released bus shows the inverse, never stale data
    assign io_in = (!ce_n && !re_n) ? sr : ~sr;
    always @(posedge we_n) begin
        if (!ce_n && cle && (!busy || io_out == 8'hFF)) begin
            if (io_out == 8'hFF && !rs) begin
                {pf, cur} <= 2'h0;
                rs <= 1'b1;
                busy <= 1'b1;
                busy <= #300 1'b0;
            end else if (io_out == 8'hD0 || io_out[7:4] == 4'h1) begin
                rs <= 1'b0;
                pf <= cur;
                cur <= fail_in;
                busy <= 1'b1;
                busy <= #2000 1'b0;
            end
        end
    end
endmodule // nand_flash_model

// ---- tb/nand_host_ctrl_test.sv ----
`timescale 1ns/100ps
module nand_host_ctrl_test;
    reg         sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0;
    reg         avs_write = 1'b0, fail_in = 1'b0;
    reg  [4:0]  avs_address = 5'h00;
    reg  [31:0] avs_writedata = 32'h0, q;
    reg  [7:0]  s = 8'hB3;
    wire [31:0] avs_readdata;
    wire [7:0]  io_in, io_out;
    wire        avs_waitrequest, ce_n, cle, ale, we_n, re_n, wp_n, rb, io_oe;
    integer     err_total = 0, checked = 0, cyc = 0, epf = 0, ecur = 0, i;
    always #12.5 sys_clk = ~sys_clk;
    nand_host_ctrl nand_host_ctrl_inst(.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .wp_n(wp_n), .ready_busy_output(rb), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe));
    nand_flash_model nand_flash_model_inst(.ce_n(ce_n), .cle(cle),
        .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .fail_in(fail_in),
        .io_out(io_out), .rb(rb), .io_in(io_in));
    // ---
    // Avalon master and checks
    // ---
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    // Answer taken at the rising edge, before that edge's updates land
    task xfer(input w, input [4:0] a, input [31:0] d);
        reg wt;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            wt = avs_waitrequest;
            q = avs_readdata;
        end while (wt);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task go(input [2:0] op);
        xfer(1'b1, 5'h00, {29'h0, op});
        do xfer(1'b0, 5'h0C, 32'h0); while (q[8]);
    endtask
    task conf(input integer f);
        epf = ecur;
        ecur = f;
    endtask
    task data(input integer n);
        repeat (n) begin
            s = lfsr(s);
            xfer(1'b1, 5'h08, {24'h0, s});
        end
    endtask
    task stat(input integer n);
        xfer(1'b0, 5'h0C, 32'h0);
        chk({q[10], q[7:0]}, {1'b0, 3'h7, 3'h0, epf[0], ecur[0]});
        $display("test %0d done", n);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        xfer(1'b0, 5'h10, 32'h0);
        chk(q, 32'h0);
        xfer(1'b0, 5'h14, 32'h0);
        chk(q, 32'h0);
        xfer(1'b1, 5'h10, 32'h1);
        xfer(1'b0, 5'h10, 32'h0);
        chk({q[31:1], wp_n}, 32'h1);
        for (i = 0; i < 2; i = i + 1) begin
            fail_in <= i[0];
            s = lfsr(s);
            xfer(1'b1, 5'h04, {s, s, 16'h0});
            go(3'h5);
            conf(i);
            stat(i);
        end
        xfer(1'b1, 5'h04, {s, 24'h0});
        xfer(1'b0, 5'h04, 32'h0);
        chk(q, {s, 24'h0});
        go(3'h1);
        data(4);
        go(3'h3);
        conf(1);
        stat(2);
        fail_in <= 1'b0;
        go(3'h1);
        data(3);
        go(3'h2);
        conf(0);
        fail_in <= 1'b1;
        go(3'h1);
        data(2);
        go(3'h4);
        conf(1);
        stat(3);
        xfer(1'b1, 5'h08, {24'h0, s});
        xfer(1'b0, 5'h0C, 32'h0);
        chk({31'h0, q[10]}, 32'h1);
        xfer(1'b1, 5'h00, 32'h100);
        stat(4);
        go(3'h6);
        conf(0);
        conf(0);
        go(3'h7);
        stat(5);
        stop_test;
    end
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    task stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
endmodule // nand_host_ctrl_test
bind nand_host_ctrl nand_host_ctrl_checker checker_inst(.sys_clk(sys_clk),
    .rst_b(rst_b), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_oe(io_oe), .io_out(io_out));
